// ==== core/tlic_pkg.sv ====
// Constants of the two-level interrupt controller: register indices, field positions,
// reset values and the primary group layout.
// Assumes an APB bus with 32-bit data; each register index is one aligned word.
package tlic_pkg;

	// Register indices; the byte address on the bus is four times the index.
	localparam logic [15:0] TLIC_IDX_PRIMARY_STATUS = 16'h4010;
	localparam logic [15:0] TLIC_IDX_PIN_CONFIG     = 16'h4017;
	localparam logic [15:0] TLIC_IDX_PRIMARY_MASK   = 16'h4018;
	localparam logic [15:0] TLIC_IDX_SEC_STATUS     = 16'h4020;
	localparam logic [15:0] TLIC_IDX_SEC_MASK       = 16'h4030;
	localparam logic [15:0] TLIC_IDX_GROUP_SPAN     = 16'h0010;

	// Pin configuration fields.
	localparam int TLIC_POS_GLOBAL_MASK = 0;
	localparam int TLIC_POS_OPEN_DRAIN  = 1;

	// Number of primary groups and the status bit that each one occupies.
	localparam int TLIC_NGRP = 11;
	localparam int TLIC_GRP_BIT [TLIC_NGRP] = '{15, 14, 13, 12, 11, 8, 7, 5, 4, 1, 0};

	// Primary bits that exist; all others read as zero and ignore writes.
	localparam logic [15:0] TLIC_PRIMARY_USED = 16'hF9B3;

	// Values after reset.
	localparam logic [15:0] TLIC_RST_PRIMARY_MASK = 16'hF9B3;
	localparam logic [1:0]  TLIC_RST_PIN_CONFIG   = 2'h0;
	localparam logic [31:0] TLIC_RST_SEC_MASK     = 32'hFFFF_FFFF;
	localparam logic [31:0] TLIC_RST_ZERO         = 32'h0000_0000;

endpackage

// ==== core/tlic_top.sv ====
// Two-level interrupt controller with an APB register slave and a configurable
// active-low interrupt request pin.
// Assumes event sources and the watchdog run on mclk; the request pin wire level is
// resolved outside from irqPinOut and irqPinOe, with a pull-up in open-drain use.
//
// Notes on behaviour
// RQ1 - Secondary flags latch and stay set.
// RQ2 - Writing one clears a secondary flag.
// RQ3 - Reads never clear secondary flags.
// RQ4 - Primary is OR of unmasked secondaries.
// RQ5 - Each secondary flag has a mask bit.
// RQ6 - Primary status register is read-only.
// RQ7 - Pin low when any enabled primary set.
// RQ8 - Each primary flag has a pin mask.
// RQ9 - Config bit one selects open drain.
// RQ10 - Open drain drives low, else releases.
// RQ11 - Global mask keeps pin deasserted.
// RQ12 - Masked secondaries still set on events.
// RQ13 - Primaries update regardless of pin mask.
// RQ14 - Watchdog reset ignores all interrupt masks.
// RQ15 - Primary clears when group cleared or masked.
// RQ16 - After reset all primaries are masked.
// RQ17 - Groups at bits 15, 14, 13.
// RQ18 - Groups at bits 12, 11, 8.
// RQ19 - Host reads primary, secondary, then clears.
// RQ20 - Groups at bits 7, 5, 4, 1, 0.
// RQ21 - Primary mask bits align, reset to one.
// RQ22 - Zero write ignored; event beats clear.
// RQ23 - Request pin driven from a register.
module tlic_top
	import tlic_pkg::*;
#(
	parameter int SEC_W  = 8,
	parameter int ADDR_W = 18
) (
	input  wire logic                      mclk,
	input  wire logic                      srst,
	input  wire logic                      psel,
	input  wire logic                      penable,
	input  wire logic                      pwrite,
	input  wire logic [ADDR_W-1:0]         paddr,
	input  wire logic [31:0]               pwdata,
	output logic      [31:0]               prdata,
	output logic                           pready,
	output logic                           pslverr,
	input  wire logic [TLIC_NGRP*SEC_W-1:0] secEvent,
	input  wire logic                      wdogResetReq,
	output logic                           wdogResetOut,
	output logic                           irqPinOut,
	output logic                           irqPinOe
);

	initial begin
		if (SEC_W < 1 || SEC_W > 32) begin
			$error("SEC_W must lie between 1 and 32.");
		end
		if (ADDR_W < 18 || ADDR_W > 32) begin
			$error("ADDR_W must lie between 18 and 32.");
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Bus decode.

	logic [15:0]      regIdx;
	logic             setupPhase;
	logic             wrStrobe;
	logic [15:0]      secStatusOff;
	logic [15:0]      secMaskOff;
	logic [15:0]      primaryStatus;
	logic [15:0]      primaryMask;
	logic [1:0]       pinConfig;
	logic [SEC_W-1:0] secFlag [TLIC_NGRP];
	logic [SEC_W-1:0] secMask [TLIC_NGRP];

	assign regIdx       = paddr[17:2];
	assign setupPhase   = psel && !penable;
	// A write takes effect only at the edge where the completed access is sampled.
	assign wrStrobe     = psel && penable && pready && pwrite;
	assign secStatusOff = regIdx - TLIC_IDX_SEC_STATUS;
	assign secMaskOff   = regIdx - TLIC_IDX_SEC_MASK;

	////////////////////////////////////////////////////////////////////////////////
	// Secondary flags, secondary masks and primary flags, one slice per group.

	logic [TLIC_NGRP-1:0] groupActive;

	for (genvar g = 0; g < TLIC_NGRP; g++) begin : gen_group
		logic             clrHit;
		logic             maskHit;
		logic [SEC_W-1:0] evt;

		assign evt     = secEvent[g*SEC_W +: SEC_W];
		assign clrHit  = wrStrobe && (regIdx == TLIC_IDX_SEC_STATUS + 16'(g));
		assign maskHit = wrStrobe && (regIdx == TLIC_IDX_SEC_MASK + 16'(g));

		// Reads have no path into this process, so they cannot clear a flag.
		always_ff @(posedge mclk) begin // RQ3
			if (srst) begin
				secFlag[g] <= SEC_W'(TLIC_RST_ZERO);
			end else if (clrHit) begin
				// Ones clear, zeros leave the flag alone, and a new event wins.
				secFlag[g] <= (secFlag[g] & ~pwdata[SEC_W-1:0]) | evt; // RQ2 RQ22
			end else begin
				// The mask is not consulted here: masked flags still latch.
				secFlag[g] <= secFlag[g] | evt; // RQ1 RQ12
			end
		end

		always_ff @(posedge mclk) begin // RQ5
			if (srst) begin
				secMask[g] <= SEC_W'(TLIC_RST_SEC_MASK);
			end else if (maskHit) begin
				secMask[g] <= pwdata[SEC_W-1:0];
			end
		end

		// Mask bit set means the flag does not reach the primary.
		assign groupActive[g] = |(secFlag[g] & ~secMask[g]); // RQ4 RQ15
	end

	// Primary bits follow their groups whatever the pin mask says; bus writes never
	// reach this register.
	always_ff @(posedge mclk) begin // RQ6 RQ13
		if (srst) begin
			primaryStatus <= 16'h0000;
		end else begin
			for (int g = 0; g < TLIC_NGRP; g++) begin
				primaryStatus[TLIC_GRP_BIT[g]] <= groupActive[g]; // RQ17 RQ18 RQ20
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Primary pin masks and pin configuration.

	always_ff @(posedge mclk) begin
		if (srst) begin
			primaryMask <= TLIC_RST_PRIMARY_MASK; // RQ16 RQ21
		end else if (wrStrobe && regIdx == TLIC_IDX_PRIMARY_MASK) begin
			primaryMask <= pwdata[15:0] & TLIC_PRIMARY_USED; // RQ8 RQ21
		end
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			pinConfig <= TLIC_RST_PIN_CONFIG;
		end else if (wrStrobe && regIdx == TLIC_IDX_PIN_CONFIG) begin
			pinConfig <= pwdata[1:0];
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Interrupt request pin.

	logic pinAssert;

	assign pinAssert = (|(primaryStatus & ~primaryMask)) && !pinConfig[TLIC_POS_GLOBAL_MASK]; // RQ7 RQ11

	// Both pin signals come from flops so the shared line sees no decode glitches.
	always_ff @(posedge mclk) begin // RQ23
		if (srst) begin
			irqPinOut <= 1'b1;
			irqPinOe  <= 1'b1;
		end else if (pinConfig[TLIC_POS_OPEN_DRAIN]) begin // RQ9
			// Pull low when asserted, otherwise let the pull-up raise the line.
			irqPinOut <= 1'b0; // RQ10
			irqPinOe  <= pinAssert; // RQ10
		end else begin
			irqPinOut <= !pinAssert; // RQ7
			irqPinOe  <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Watchdog reset action, which no interrupt mask may suppress.

	always_ff @(posedge mclk) begin
		if (srst) begin
			wdogResetOut <= 1'b0;
		end else begin
			wdogResetOut <= wdogResetReq; // RQ14
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Bus answer: one wait-free access cycle, read data captured in the setup cycle.

	logic [31:0] next_prdata;
	logic        next_pslverr;

	always_comb begin
		next_prdata  = 32'h0000_0000;
		next_pslverr = 1'b0;
		if (regIdx == TLIC_IDX_PRIMARY_STATUS) begin
			next_prdata[15:0] = primaryStatus;
			next_pslverr      = pwrite;
		end else if (regIdx == TLIC_IDX_PIN_CONFIG) begin
			next_prdata[1:0] = pinConfig;
		end else if (regIdx == TLIC_IDX_PRIMARY_MASK) begin
			next_prdata[15:0] = primaryMask;
		end else if (secStatusOff < 16'(TLIC_NGRP)) begin
			next_prdata[SEC_W-1:0] = secFlag[secStatusOff[3:0]];
		end else if (secMaskOff < 16'(TLIC_NGRP)) begin
			next_prdata[SEC_W-1:0] = secMask[secMaskOff[3:0]];
		end else begin
			next_pslverr = 1'b1;
		end
		// A shift rather than a part-select keeps the default 18-bit address legal.
		if (paddr[1:0] != 2'b00 || (paddr >> 18) != '0) begin
			next_prdata  = 32'h0000_0000;
			next_pslverr = 1'b1;
		end
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end else begin
			pready  <= setupPhase;
			pslverr <= setupPhase && next_pslverr;
			if (setupPhase && !pwrite) begin
				prdata <= next_prdata;
			end
		end
	end

endmodule

// ==== verif/tlic_host_line.sv ====
// Host side of the request line: the pull-up on the shared wire.
// Assumes the device gives pin level and enable separately.
module tlic_host_line (
	input wire logic	pinOut,
	input wire logic	pinOe,
	output logic		irqLine
);
	timeunit 1ns;
	timeprecision 1ns;
	// A released line reads high through the pull-up.
	assign irqLine = pinOe ? pinOut : 1'b1;
endmodule

// ==== verif/tlic_properties.sv ====
// Port checker of the interrupt controller.
// Bound into tlic_top; it sees only that module's ports.
module tlic_properties
	import tlic_pkg::*;
#(
	parameter int SEC_W  = 8,
	parameter int ADDR_W = 18
) (
	input wire logic				mclk,
	input wire logic				srst,
	input wire logic				psel,
	input wire logic				penable,
	input wire logic				pwrite,
	input wire logic [ADDR_W-1:0]			paddr,
	input wire logic [31:0]				prdata,
	input wire logic				pready,
	input wire logic				pslverr,
	input wire logic [TLIC_NGRP*SEC_W-1:0]	secEvent,
	input wire logic				wdogResetReq,
	input wire logic				wdogResetOut,
	input wire logic				irqPinOut,
	input wire logic				irqPinOe
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge mclk);
	endclocking
	default disable iff (srst);
	localparam logic [ADDR_W-1:0] RO = ADDR_W'({TLIC_IDX_PRIMARY_STATUS, 2'b00});
	////////////////////////////////////////////////////////////////
	sequence s_set;
		psel && !penable;
	endsequence
	property p_rdy;
		s_set |=> penable && pready;
	endproperty
	a_rdy: assert property (p_rdy) else $error("ready missing");
	property p_one;
		pready |=> !pready;
	endproperty
	a_one: assert property (p_one) else $error("ready too long");
	property p_ro;
		s_set ##0 (pwrite && paddr == RO) |=> pslverr;
	endproperty
	a_ro: assert property (p_ro) else $error("status write taken");
	property p_mis;
		s_set ##0 (!pwrite && paddr[1:0] != 2'b00) |=> pslverr && prdata == 32'h0000_0000;
	endproperty
	a_mis: assert property (p_mis) else $error("misaligned read");
	// The first edge after reset is skipped: the copy was forced low then.
	property p_wd;
		!$past(srst) |-> wdogResetOut == $past(wdogResetReq);
	endproperty
	a_wd: assert property (p_wd) else $error("watchdog copy wrong");
	property p_od;
		irqPinOut |-> irqPinOe;
	endproperty
	a_od: assert property (p_od) else $error("pin released high");
	property p_rst;
		$fell(srst) |-> (irqPinOut && irqPinOe)[*2];
	endproperty
	a_rst: assert property (p_rst) else $error("pin asserted at reset");
	property p_qt;
		(!psel && secEvent == '0)[*3] |=> $stable(irqPinOut) && $stable(irqPinOe);
	endproperty
	a_qt: assert property (p_qt) else $error("pin moved while quiet");
endmodule
bind tlic_top tlic_properties #(.SEC_W(SEC_W), .ADDR_W(ADDR_W)) i_chk (.*);

// ==== verif/tb.sv ====
// Directed testbench of the interrupt controller over APB.
// Assumes the checker is bound and the host line model resolves the pin.
module tb
	import tlic_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int SW = 8;
	localparam logic [15:0] PS = TLIC_IDX_PRIMARY_STATUS;
	localparam logic [15:0] SS = TLIC_IDX_SEC_STATUS;
	localparam logic [15:0] SM = TLIC_IDX_SEC_MASK;
	localparam logic [31:0] Z = TLIC_RST_ZERO;
	localparam logic [31:0] ONE = 32'h0000_0001;
	logic				mclk, srst, psel, penable, pwrite, pready, pslverr, errv;
	logic				wdogResetReq, wdogResetOut, irqPinOut, irqPinOe, irqLine;
	logic [17:0]			paddr;
	logic [31:0]			pwdata, prdata, rdv;
	logic [1:0]			adj;
	logic [TLIC_NGRP*SW-1:0]	secEvent;
	int				errors, n_compared;
	tlic_top #(.SEC_W(SW)) i_dut (.*);
	tlic_host_line i_host (.pinOut(irqPinOut), .pinOe(irqPinOe), .irqLine(irqLine));
	initial begin
		mclk = 1'b0;
		forever #4 mclk = ~mclk;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge mclk);
	endtask
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		n_compared++;
		if (got !== exp) begin
			errors++;
			$display("Error %s expected %h seen %h", nm, exp, got);
		end
	endtask
	// Holds the request until pready is sampled, then idles a cycle before the next.
	task automatic xfer(input logic w, input logic [15:0] idx, input logic [31:0] d);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= {idx, adj};
		pwdata <= d;
		tick(1);
		penable <= 1'b1;
		// Only the watchdog process ends a wait that never completes.
		do begin
			tick(1);
		end while (pready !== 1'b1);
		rdv = prdata;
		errv = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		tick(1);
	endtask
	task automatic rd(input string nm, input logic [15:0] idx, input logic [31:0] exp);
		xfer(1'b0, idx, Z);
		chk(nm, exp, rdv);
	endtask
	task automatic evt(input int g);
		secEvent[g*SW] <= 1'b1;
		tick(1);
		secEvent <= '0;
		tick(3);
	endtask
	task automatic test_done;
		$display("compared %0d mismatches %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	initial begin
		tick(5000);
		errors++;
		test_done;
	end
	////////////////////////////////////////////////////////////////
	initial begin
		{srst, psel, penable, pwrite, wdogResetReq} = 5'b10000;
		{paddr, pwdata, secEvent, adj} = '0;
		errors = 0;
		n_compared = 0;
		tick(4);
		srst <= 1'b0;
		rd("pmask", TLIC_IDX_PRIMARY_MASK, 32'h0000_F9B3);
		rd("pcfg", TLIC_IDX_PIN_CONFIG, Z);
		chk("line", 1'b1, irqLine);
		rd("unmapped", 16'h4000, Z);
		chk("unmapped err", 1'b1, errv);
		adj = 2'b01;
		rd("misaligned", TLIC_IDX_PRIMARY_MASK, Z);
		chk("misaligned err", 1'b1, errv);
		adj = 2'b00;
		$display("test 1 done");
		evt(0);
		rd("sec", SS, ONE);
		rd("sec reread", SS, ONE);
		rd("prim", PS, Z);
		xfer(1'b1, SS, Z);
		rd("sec zero", SS, ONE);
		xfer(1'b1, SM, 32'h0000_00FE);
		rd("prim", PS, 32'h0000_8000);
		chk("line", 1'b1, irqLine);
		xfer(1'b1, TLIC_IDX_PRIMARY_MASK, Z);
		tick(3);
		chk("line", 1'b0, irqLine);
		xfer(1'b1, PS, Z);
		chk("ro err", 1'b1, errv);
		rd("prim ro", PS, 32'h0000_8000);
		xfer(1'b1, TLIC_IDX_PIN_CONFIG, 32'h0000_0002);
		tick(2);
		chk("od out", 1'b0, irqPinOut);
		chk("od line", 1'b0, irqLine);
		xfer(1'b1, TLIC_IDX_PIN_CONFIG, 32'h0000_0003);
		tick(2);
		chk("gmask", 1'b1, irqLine);
		xfer(1'b1, TLIC_IDX_PIN_CONFIG, Z);
		xfer(1'b1, SM, 32'h0000_00FF);
		rd("prim masked", PS, Z);
		xfer(1'b1, SS, ONE);
		rd("sec clr", SS, Z);
		$display("test 2 done");
		for (int g = 0; g < TLIC_NGRP; g++) begin
			xfer(1'b1, SM + 16'(g), 32'h0000_00FE);
			evt(g);
			chk("line grp", 1'b0, irqLine);
			rd("grp", PS, ONE << TLIC_GRP_BIT[g]);
			rd("grp sec", SS + 16'(g), ONE);
			xfer(1'b1, SS + 16'(g), ONE);
			rd("grp clr", PS, Z);
		end
		$display("test 3 done");
		wdogResetReq <= 1'b1;
		tick(1);
		wdogResetReq <= 1'b0;
		tick(1);
		chk("wdog", 1'b1, wdogResetOut);
		$display("test 4 done");
		test_done;
	end
endmodule
